// ==== src/rst_clk_pkg.sv ====
// Package: types and constants for the reset and clock source controller
package rst_clk_pkg;

   // Number of reset sources
   localparam int unsigned SRC_COUNT      = 6;
   // Source indices inside the request vector
   localparam int unsigned SRC_SUPPLY     = 0;
   localparam int unsigned SRC_WATCHDOG   = 1;
   localparam int unsigned SRC_MISS_CLK   = 2;
   localparam int unsigned SRC_CMP0       = 3;
   localparam int unsigned SRC_SOFTWARE   = 4;
   localparam int unsigned SRC_PIN        = 5;

   // Cycles spent in ST_HOLD; the system reset is held one cycle more after all requests vanish
   localparam logic [1:0]  HOLD_CYCLES    = 2'h2;

   // Reset values
   localparam logic        RESET_SYS_RST  = 1'b1;
   localparam logic        RESET_PIN_OE_N = 1'b0;
   localparam logic [5:0]  RESET_CAUSE    = 6'h00;
   localparam logic        RESET_CLK_EXT  = 1'b0;
   localparam logic        RESET_WDT_LOCK = 1'b0;
   localparam logic        RESET_WDT_ACTIVE = 1'b1;

   typedef enum logic [1:0] {
      ST_RESET,
      ST_HOLD,
      ST_RUN
   } seq_state_t;

   // Per-source software enables (supply and pin have no enable bit)
   typedef struct packed {
      logic       wdt_en;
      logic       miss_clk_en;
      logic       cmp0_en;
      logic       soft_en;
   } src_enable_t;

   // Requests from the sources after gating and masking
   typedef struct packed {
      logic       pin;
      logic       software;
      logic       cmp0;
      logic       miss_clk;
      logic       watchdog;
      logic       supply;
   } src_request_t;

   typedef struct packed {
      seq_state_t  state;
      logic [1:0]  hold_cnt;
      logic        sys_rst;
      logic        pin_oe_n;
      logic [5:0]  cause;
      logic        clk_ext;
      logic        wdt_lock;
      logic        wdt_active;
      logic        por_done;
   } ctrl_state_t;

endpackage : rst_clk_pkg

// ==== src/reset_and_clock_source_control.sv ====
// Reset source combiner, reset pin driver and system clock source select
//
// Contract
// - System reset comes from supply, watchdog, missing clock, comparator, software, pin.
// - Reset pin is two-way: outside may pull it, device drives internal resets out.
// - Supply monitor acts only while its enable pin is high.
// - Software masks every source except supply monitor and reset pin.
// - After power-on, software may lock the watchdog on until the next power-on or supply reset.
// - Every reset selects the internal clock generator.
// - Software switches between internal and external clock while running.
`timescale 1ns/1ps

module reset_and_clock_source_control (
   // Clock, reset, enable
   input  wire logic                        clk_sys,
   input  wire logic                        arst_n,
   input  wire logic                        clk_en,
   // Source requests
   input  wire logic                        supply_low,
   input  wire logic                        supply_monitor_enable_pin,
   input  wire logic                        power_on,
   input  wire logic                        wdt_timeout,
   input  wire logic                        miss_clk_detect,
   input  wire logic                        cmp0_trip,
   input  wire logic                        soft_reset,
   // Reset pin, three signals
   input  wire logic                        rst_pin_in,
   output logic                             rst_pin_out,
   output logic                             rst_pin_oe_n,
   // Software controls
   input  rst_clk_pkg::src_enable_t         src_enable,
   input  wire logic                        wdt_disable_req,
   input  wire logic                        wdt_lock_req,
   input  wire logic                        clk_ext_sel,
   // Status
   output logic                             sys_rst,
   output logic [5:0]                       reset_cause,
   output logic                             clk_ext_active,
   output logic                             wdt_locked,
   output logic                             wdt_enabled
);

   ////////////////////////////////////////////////////////////////////////////
   rst_clk_pkg::ctrl_state_t   st;
   rst_clk_pkg::ctrl_state_t   next_st;
   rst_clk_pkg::src_request_t  req;
   logic                       internal_any;
   logic                       any_req;
   logic                       pin_ext;

   // Our own drive shows on the pin; only count the pin as external when we are not driving
   assign pin_ext = !rst_pin_in && st.pin_oe_n;

   always_comb begin
      req          = '0;
      req.supply   = supply_low && supply_monitor_enable_pin;
      req.watchdog = wdt_timeout && st.wdt_active;
      req.miss_clk = miss_clk_detect && src_enable.miss_clk_en;
      req.cmp0     = cmp0_trip && src_enable.cmp0_en;
      req.software = soft_reset && src_enable.soft_en;
      req.pin      = pin_ext;
   end

   assign internal_any = req.supply || req.watchdog || req.miss_clk
                      || req.cmp0 || req.software;
   assign any_req      = internal_any || req.pin;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_st = st;
      case (st.state)
         rst_clk_pkg::ST_RESET: begin
            if (!any_req) begin
               next_st.state    = rst_clk_pkg::ST_HOLD;
               next_st.hold_cnt = '0;
            end
         end
         rst_clk_pkg::ST_HOLD: begin
            // A bouncing source restarts the hold, so reset never chatters
            if (any_req) begin
               next_st.state = rst_clk_pkg::ST_RESET;
            end else if (st.hold_cnt == rst_clk_pkg::HOLD_CYCLES - 2'h1) begin
               next_st.state    = rst_clk_pkg::ST_RUN;
               next_st.sys_rst  = 1'b0;
               next_st.pin_oe_n = 1'b1;
               next_st.por_done = 1'b1;
            end else begin
               next_st.hold_cnt = st.hold_cnt + 2'h1;
            end
         end
         rst_clk_pkg::ST_RUN: begin
            // Lock taken in any run cycle; sticky until power-on or supply reset
            if (wdt_lock_req && !st.por_done) begin
               next_st.wdt_lock = 1'b1;
            end
            if (wdt_lock_req && st.por_done && !st.wdt_lock) begin
               next_st.wdt_lock = 1'b1;
            end
            if (st.wdt_lock) begin
               next_st.wdt_active = 1'b1;
            end else begin
               next_st.wdt_active = src_enable.wdt_en && !wdt_disable_req;
            end
            next_st.clk_ext = clk_ext_sel;
            if (any_req) begin
               next_st.state    = rst_clk_pkg::ST_RESET;
               next_st.sys_rst  = 1'b1;
               next_st.pin_oe_n = !internal_any;
               next_st.cause    = req;
               next_st.clk_ext  = 1'b0;
               // A supply reset clears the lock; other sources leave it set
               if (req.supply) begin
                  next_st.wdt_lock = 1'b0;
               end
            end
         end
         default: begin
            next_st.state = rst_clk_pkg::ST_RESET;
         end
      endcase
      if (st.state != rst_clk_pkg::ST_RUN) begin
         next_st.clk_ext = 1'b0;
         if (internal_any) begin
            next_st.pin_oe_n = 1'b0;
         end
      end
      if (power_on) begin
         next_st.wdt_lock   = 1'b0;
         next_st.wdt_active = 1'b1;
         next_st.por_done   = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st            <= '0;
         st.state      <= rst_clk_pkg::ST_RESET;
         st.sys_rst    <= rst_clk_pkg::RESET_SYS_RST;
         st.pin_oe_n   <= rst_clk_pkg::RESET_PIN_OE_N;
         st.cause      <= rst_clk_pkg::RESET_CAUSE;
         st.clk_ext    <= rst_clk_pkg::RESET_CLK_EXT;
         st.wdt_lock   <= rst_clk_pkg::RESET_WDT_LOCK;
         st.wdt_active <= rst_clk_pkg::RESET_WDT_ACTIVE;
      end else if (clk_en) begin
         st <= next_st;
      end
   end

   assign rst_pin_out    = 1'b0;
   assign rst_pin_oe_n   = st.pin_oe_n;
   assign sys_rst        = st.sys_rst;
   assign reset_cause    = st.cause;
   assign clk_ext_active = st.clk_ext;
   assign wdt_locked     = st.wdt_lock;
   assign wdt_enabled    = st.wdt_active;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   // Gate and mask antecedents keep other sources quiet so each source is judged alone

   any_source_a: assert property (clk_en && any_req |=> sys_rst)
      else $error("reset request did not assert system reset");
   pin_drive_a: assert property (clk_en && internal_any |=> !rst_pin_oe_n)
      else $error("internal reset not driven on pin");
   quiet_run_a: assert property (
      clk_en && st.state == rst_clk_pkg::ST_RUN && !any_req |=> !sys_rst)
      else $error("reset without enabled source");
   monitor_gate_a: assert property (
      clk_en && st.state == rst_clk_pkg::ST_RUN && supply_low && !supply_monitor_enable_pin
      && !req.watchdog && !req.miss_clk && !req.cmp0 && !req.software && !req.pin
      |=> !sys_rst)
      else $error("supply monitor acted while disabled");
   mask_misc_a: assert property (
      clk_en && st.state == rst_clk_pkg::ST_RUN && cmp0_trip && !src_enable.cmp0_en
      && !supply_low && !wdt_timeout && !miss_clk_detect && !soft_reset && rst_pin_in
      |=> !sys_rst)
      else $error("masked comparator caused reset");
   lock_hold_a: assert property (
      clk_en && wdt_locked && !power_on && !supply_low |=> wdt_locked)
      else $error("watchdog lock lost");
   clk_default_a: assert property (sys_rst |-> !clk_ext_active)
      else $error("external clock during reset");
   clk_switch_a: assert property (
      clk_en && st.state == rst_clk_pkg::ST_RUN && !any_req
      |=> clk_ext_active == $past(clk_ext_sel))
      else $error("clock select not followed");
   release_a: assert property (
      clk_en && st.state == rst_clk_pkg::ST_RESET && !any_req ##1 clk_en && !any_req
      ##1 clk_en && !any_req |=> !sys_rst)
      else $error("reset not released");
   pin_external_a: assert property (
      clk_en && st.state == rst_clk_pkg::ST_RUN && req.pin && !internal_any |=> rst_pin_oe_n)
      else $error("external reset driven back on pin");
   cause_soft_a: assert property (
      clk_en && st.state == rst_clk_pkg::ST_RUN && req.software |=> reset_cause[4])
      else $error("software reset cause not captured");
   wdt_off_a: assert property (
      clk_en && st.state == rst_clk_pkg::ST_RUN && !wdt_locked && wdt_disable_req && !power_on
      |=> !wdt_enabled)
      else $error("unlocked watchdog not disabled");
   lock_set_a: assert property (
      clk_en && st.state == rst_clk_pkg::ST_RUN && wdt_lock_req && !power_on && !supply_low
      |=> wdt_locked)
      else $error("watchdog lock request ignored");
   clk_reset_a: assert property (
      clk_en && st.state != rst_clk_pkg::ST_RUN |=> !clk_ext_active)
      else $error("external clock selected outside run");
   sys_rst_hold_a: assert property (
      clk_en && st.state == rst_clk_pkg::ST_RESET |=> sys_rst)
      else $error("system reset dropped while requested");
   pin_release_a: assert property (
      clk_en && st.state == rst_clk_pkg::ST_HOLD && !any_req
      && st.hold_cnt == rst_clk_pkg::HOLD_CYCLES - 2'h1 |=> rst_pin_oe_n && !sys_rst)
      else $error("reset not released after hold");

   // Main scenarios
   cov_pin_c: cover property (req.pin ##[1:20] !sys_rst);
   cov_wdt_c: cover property (req.watchdog ##[1:20] !sys_rst);
   cov_clk_c: cover property (!clk_ext_active ##1 clk_ext_active);
   cov_lock_c: cover property (wdt_lock_req ##1 wdt_locked);
   cov_mask_c: cover property (st.state == rst_clk_pkg::ST_RUN && cmp0_trip && !src_enable.cmp0_en);

endmodule : reset_and_clock_source_control

// ==== bench/ext_reset_party.sv ====
// External reset circuitry model on the far side of the reset pin
`timescale 1ns/1ps

module ext_reset_party (
   // Device side of the pin
   input  wire logic rst_pin_out,
   input  wire logic rst_pin_oe_n,
   // Outside party request
   input  wire logic pull_low,
   // Resolved pin level
   output logic      rst_pin_in
);
   // Open drain with pull-up: low if either party pulls, high otherwise
   assign rst_pin_in = !((!rst_pin_oe_n && !rst_pin_out) || pull_low);
endmodule : ext_reset_party

// ==== bench/reset_and_clock_source_control_tb_top.sv ====
// Testbench for the reset and clock source controller
`timescale 1ns/1ps

module reset_and_clock_source_control_tb_top;
   logic                      clk_sys  = 1'b0;
   logic                      arst_n   = 1'b0;
   logic                      clk_en   = 1'b1;
   logic [5:0]                req      = 6'h00;
   logic                      mon_en   = 1'b1;
   logic                      power_on = 1'b1;
   rst_clk_pkg::src_enable_t  src_enable = 4'hF;
   logic                      wd_off   = 1'b0;
   logic                      wd_lock  = 1'b0;
   logic                      clk_sel  = 1'b0;
   logic                      rst_pin_in, rst_pin_out, rst_pin_oe_n, sys_rst;
   logic                      clk_ext_active, wdt_locked, wdt_enabled;
   logic [5:0]                reset_cause;
   int                        fails = 0;
   int                        comparisons = 0;
   int                        cycles = 0;

   ext_reset_party partner (.rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n),
      .pull_low(req[5]), .rst_pin_in(rst_pin_in));

   reset_and_clock_source_control dut (.clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en),
      .supply_low(req[0]), .supply_monitor_enable_pin(mon_en), .power_on(power_on),
      .wdt_timeout(req[1]), .miss_clk_detect(req[2]), .cmp0_trip(req[3]),
      .soft_reset(req[4]), .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out),
      .rst_pin_oe_n(rst_pin_oe_n), .src_enable(src_enable), .wdt_disable_req(wd_off),
      .wdt_lock_req(wd_lock), .clk_ext_sel(clk_sel), .sys_rst(sys_rst),
      .reset_cause(reset_cause), .clk_ext_active(clk_ext_active),
      .wdt_locked(wdt_locked), .wdt_enabled(wdt_enabled));

   initial begin
      forever #50 clk_sys = ~clk_sys;
   end

   task automatic check(input string what, input logic [5:0] got, input logic [5:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #5;
   endtask : step

   // One-cycle request; the reset must hold through the release count
   task automatic fire(input int idx, input logic hit, input logic drive);
      req[idx] = 1'b1;
      step(1);
      req[idx] = 1'b0;
      check("sys_rst", sys_rst, hit);
      if (hit) check("reset_cause", reset_cause, 6'h01 << idx);
      check("rst_pin_oe_n", rst_pin_oe_n, !(hit && drive));
      step(1);
      check("sys_rst", sys_rst, hit);
      step(2);
      check("sys_rst", sys_rst, 1'b0);
      check("rst_pin_oe_n", rst_pin_oe_n, 1'b1);
   endtask : fire

   task automatic wrap_up;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : wrap_up

   // Hang guard, well above the length of the sequence
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 2000) begin
         fails++;
         wrap_up();
      end
   end

   initial begin
      repeat (3) @(posedge clk_sys);
      #5;
      arst_n = 1'b1;
      power_on = 1'b0;
      step(4);
      check("sys_rst", sys_rst, 1'b0);
      check("clk_ext_active", clk_ext_active, 1'b0);
      wd_lock = 1'b1;
      step(1);
      wd_lock = 1'b0;
      check("wdt_locked", wdt_locked, 1'b1);
      wd_off = 1'b1;
      step(1);
      check("wdt_enabled", wdt_enabled, 1'b1);
      wd_off = 1'b0;
      step(1);
      for (int i = 0; i < 5; i++) fire(i, 1'b1, 1'b1);
      fire(5, 1'b1, 1'b0);
      src_enable = 4'h0;
      // Watchdog mask is registered, let it settle first
      step(1);
      for (int i = 1; i < 5; i++) fire(i, 1'b0, 1'b1);
      fire(0, 1'b1, 1'b1);
      fire(5, 1'b1, 1'b0);
      src_enable = 4'hF;
      mon_en = 1'b0;
      fire(0, 1'b0, 1'b1);
      mon_en = 1'b1;
      clk_sel = 1'b1;
      step(1);
      check("clk_ext_active", clk_ext_active, 1'b1);
      check("sys_rst", sys_rst, 1'b0);
      req[4] = 1'b1;
      step(1);
      req[4] = 1'b0;
      check("clk_ext_active", clk_ext_active, 1'b0);
      step(3);
      check("clk_ext_active", clk_ext_active, 1'b0);
      step(1);
      check("clk_ext_active", clk_ext_active, 1'b1);
      clk_sel = 1'b0;
      step(1);
      check("clk_ext_active", clk_ext_active, 1'b0);
      // Supply reset above cleared the lock, so the watchdog may now be turned off
      wd_off = 1'b1;
      step(1);
      check("wdt_enabled", wdt_enabled, 1'b0);
      fire(1, 1'b0, 1'b1);
      wd_off = 1'b0;
      // Frozen by the clock enable: neither request nor select takes effect
      clk_en = 1'b0;
      clk_sel = 1'b1;
      req[4] = 1'b1;
      step(1);
      check("sys_rst", sys_rst, 1'b0);
      check("clk_ext_active", clk_ext_active, 1'b0);
      clk_en = 1'b1;
      req[4] = 1'b0;
      step(1);
      check("clk_ext_active", clk_ext_active, 1'b1);
      // Mid-run power-on reset drops the lock and the external clock
      wd_lock = 1'b1;
      step(1);
      wd_lock = 1'b0;
      check("wdt_locked", wdt_locked, 1'b1);
      arst_n = 1'b0;
      power_on = 1'b1;
      step(1);
      check("sys_rst", sys_rst, 1'b1);
      check("rst_pin_oe_n", rst_pin_oe_n, 1'b0);
      check("clk_ext_active", clk_ext_active, 1'b0);
      check("wdt_locked", wdt_locked, 1'b0);
      arst_n = 1'b1;
      power_on = 1'b0;
      step(3);
      check("sys_rst", sys_rst, 1'b0);
      check("clk_ext_active", clk_ext_active, 1'b0);
      step(1);
      check("clk_ext_active", clk_ext_active, 1'b1);
      wrap_up();
   end
endmodule : reset_and_clock_source_control_tb_top
